// *** hw/tpw_pkg.sv ***
// package for the 8-bit timer pwm waveform block: map, fields, reset values
package tpw_pkg;

    // register byte offsets on the wishbone bus
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_CMP_A   = 4'h4;
    localparam logic [3:0] ADDR_CMP_B   = 4'h8;
    localparam logic [3:0] ADDR_STATUS  = 4'hC;

    // control register field positions
    localparam int CTRL_WGM_LSB    = 0;
    localparam int CTRL_PRESC_LSB  = 4;
    localparam int CTRL_COMB_LSB   = 8;
    localparam int CTRL_COMA_LSB   = 10;

    // status register field positions (write one to clear)
    localparam int STAT_OVF_BIT    = 0;
    localparam int STAT_CMPA_BIT   = 1;
    localparam int STAT_CMPB_BIT   = 2;
    localparam int STAT_CNT_LSB    = 8;

    // waveform mode encodings
    localparam logic [2:0] WGM_PC_FF    = 3'h1;
    localparam logic [2:0] WGM_FAST_FF  = 3'h3;
    localparam logic [2:0] WGM_PC_OCA   = 3'h5;
    localparam logic [2:0] WGM_FAST_OCA = 3'h7;

    // compare output mode encodings
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_NONINV = 2'h2;
    localparam logic [1:0] COM_INV    = 2'h3;

    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hFF;

    // prescale selects: 0 stop, 1..5 divide by 1, 8, 64, 256, 1024
    localparam logic [2:0] PRESC_STOP = 3'h0;
    localparam logic [2:0] PRESC_1    = 3'h1;
    localparam logic [2:0] PRESC_8    = 3'h2;
    localparam logic [2:0] PRESC_64   = 3'h3;
    localparam logic [2:0] PRESC_256  = 3'h4;
    localparam logic [2:0] PRESC_1024 = 3'h5;
    localparam int         PRESC_W    = 10;

    localparam logic [31:0] RST_ZERO  = 32'h0000_0000;

    typedef struct packed {
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic [2:0] presc;
        logic [2:0] wgm;
    } tpw_ctrl_s;

endpackage : tpw_pkg

// *** hw/tpw_prescaler.sv ***
// prescaler: one-cycle timer clock enable pulses from the io clock
`timescale 1ns/1ns
module tpw_prescaler
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic [2:0] presc_sel,
    output logic            tick
);

    logic [tpw_pkg::PRESC_W-1:0] div_ff;
    logic                        hit;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            div_ff <= '0;
        else
            div_ff <= div_ff + 1'b1;
    end

    always_comb
    begin
        case (presc_sel)
            tpw_pkg::PRESC_1:    hit = 1'b1;
            tpw_pkg::PRESC_8:    hit = (div_ff[2:0] == 3'h7);
            tpw_pkg::PRESC_64:   hit = (div_ff[5:0] == 6'h3F);
            tpw_pkg::PRESC_256:  hit = (div_ff[7:0] == 8'hFF);
            tpw_pkg::PRESC_1024: hit = (div_ff == 10'h3FF);
            default:             hit = 1'b0;
        endcase
    end

    // enable, not a derived clock, keeps the timer fully synchronous
    assign tick = hit;

endmodule : tpw_prescaler

// *** hw/tpw_wave_ch.sv ***
// one compare channel: match detect and waveform output register
`timescale 1ns/1ns
module tpw_wave_ch
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       tick,
    input  wire logic       fast,
    input  wire logic       pc,
    input  wire logic       wgm2,
    input  wire logic       toggle_ok,
    input  wire logic [1:0] com,
    input  wire logic [7:0] cnt,
    input  wire logic [7:0] top,
    input  wire logic [7:0] cmp,
    input  wire logic       up,
    input  wire logic       at_top,
    input  wire logic       at_bottom,
    output logic            match,
    output logic            wave_ff
);

    logic nxt_wave;
    logic inv;
    logic cmp_is_top;

    assign match      = tick && (cnt == cmp);
    assign inv        = (com == tpw_pkg::COM_INV);
    assign cmp_is_top = (cmp == top);

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_wave = wave_ff;
        if (tick && com == tpw_pkg::COM_TOGGLE && wgm2 && toggle_ok && match)
            nxt_wave = ~wave_ff;
        else if (tick && com[1] && fast)
        begin
            // match at top is ignored; level decided at the wrap
            if (at_top)
                nxt_wave = ~inv;
            else if (match)
                nxt_wave = inv;
        end
        else if (tick && com[1] && pc)
        begin
            if (cmp_is_top && at_top)
                nxt_wave = ~inv;
            // a match at bottom is the turnaround; the bottom branches own it
            else if (match && !cmp_is_top && !at_bottom)
                nxt_wave = up ? inv : ~inv;
            else if (at_bottom && cmp != tpw_pkg::CNT_BOTTOM)
                // restore down-count match result at bottom for symmetry
                nxt_wave = ~inv;
            else if (at_bottom)
                nxt_wave = inv;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            wave_ff <= 1'b0;
        else
            wave_ff <= nxt_wave;
    end

endmodule : tpw_wave_ch

// *** hw/tpw_timer.sv ***
// top: 8-bit timer with fast and phase correct pwm, wishbone registers
`timescale 1ns/1ns
//
// Summary of operation
// - mode 3 or 7 selects fast pwm, counting up bottom to top.
// - fast pwm top is 0xFF in mode 3, compare a in mode 7.
// - fast pwm: mode 2 clears on match sets at bottom; 3 inverts.
// - counter clears the cycle after top; bottom output change then.
// - fast pwm sets overflow flag whenever counter reaches top.
// - fast pwm: channel a mode 1 with bit 2 toggles; b cannot.
// - fast pwm: compare a bottom gives spike; max gives steady level.
// - toggle mode gives 50% square wave, fastest at compare zero.
// - compare values are double buffered in pwm modes.
// - top 0xFF gives 256 timer cycle fast pwm period.
// - mode 1 or 5 selects phase correct pwm, up then down.
// - phase correct top is 0xFF in mode 1, compare a in 5.
// - phase correct: mode 2 clears on up match, sets down; 3 inverts.
// - counter reverses at top, holding top for one timer cycle.
// - phase correct sets overflow flag at bottom.
// - phase correct: channel a mode 1 with bit 2 toggles; b cannot.
// - top 0xFF gives 510 timer cycle phase correct period.
// - compare bottom gives steady low, max steady high; inverted opposite.
// - reaching max, output flips at the next bottom without match.
// - missed down match still applied at bottom for symmetry.
// - timer clock is an enable on the io clock, not a clock.
// - reset clears the channel output registers to zero.
//
module tpw_timer
(
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    output logic             channel_a_output,
    output logic             channel_b_output,
    output logic             channel_a_oe,
    output logic             channel_b_oe
);

    tpw_pkg::tpw_ctrl_s ctrl_ff;
    logic [7:0]         cmp_a_buf_ff;
    logic [7:0]         cmp_b_buf_ff;
    logic [7:0]         cmp_a_ff;
    logic [7:0]         cmp_b_ff;
    logic [7:0]         counter_value_ff;
    logic               up_ff;
    logic               overflow_flag_ff;
    logic               compare_a_flag_ff;
    logic               compare_b_flag_ff;
    logic               ack_ff;
    logic               err_ff;
    logic [31:0]        rdata_ff;
    logic               out_a_ff;
    logic               out_b_ff;
    logic               oe_a_ff;
    logic               oe_b_ff;

    logic               timer_clock_enable;
    logic               fast;
    logic               pc;
    logic [7:0]         top;
    logic               at_top;
    logic               at_bottom;
    logic               match_a;
    logic               match_b;
    logic               wave_a;
    logic               wave_b;
    logic               wr;
    logic               rd;
    logic               mapped;
    logic               ovf_set;
    logic               update_cmp;
    logic [31:0]        nxt_rdata;

    ////////////////////////////////////////////////////////////////////////
    // mode decode
    assign fast = (ctrl_ff.wgm == tpw_pkg::WGM_FAST_FF)
               || (ctrl_ff.wgm == tpw_pkg::WGM_FAST_OCA);
    assign pc   = (ctrl_ff.wgm == tpw_pkg::WGM_PC_FF)
               || (ctrl_ff.wgm == tpw_pkg::WGM_PC_OCA);
    assign top  = ctrl_ff.wgm[2] ? cmp_a_ff : tpw_pkg::CNT_MAX;
    assign at_top    = (counter_value_ff == top);
    assign at_bottom = (counter_value_ff == tpw_pkg::CNT_BOTTOM);

    tpw_prescaler u_presc
    (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .presc_sel (ctrl_ff.presc),
        .tick      (timer_clock_enable)
    );

    ////////////////////////////////////////////////////////////////////////
    // counter: with top 0xFF, 256 cycles per fast period, 510 per phase correct period
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            counter_value_ff <= tpw_pkg::CNT_BOTTOM;
            up_ff            <= 1'b1;
        end
        else if (timer_clock_enable)
        begin
            if (pc)
            begin
                if (up_ff && at_top)
                begin
                    up_ff            <= 1'b0;
                    counter_value_ff <= counter_value_ff - 8'h01;
                end
                else if (!up_ff && at_bottom)
                begin
                    up_ff            <= 1'b1;
                    counter_value_ff <= counter_value_ff + 8'h01;
                end
                else if (up_ff)
                    counter_value_ff <= counter_value_ff + 8'h01;
                else
                    counter_value_ff <= counter_value_ff - 8'h01;
            end
            else
            begin
                up_ff <= 1'b1;
                if (fast && at_top)
                    counter_value_ff <= tpw_pkg::CNT_BOTTOM;
                else
                    counter_value_ff <= counter_value_ff + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // double buffer: the compare values load at top in pwm modes
    assign update_cmp = !(fast || pc) || (timer_clock_enable && at_top);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            cmp_a_ff <= 8'h00;
            cmp_b_ff <= 8'h00;
        end
        else if (update_cmp)
        begin
            cmp_a_ff <= cmp_a_buf_ff;
            cmp_b_ff <= cmp_b_buf_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // waveform channels; only channel a may toggle
    tpw_wave_ch u_ch_a
    (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .tick      (timer_clock_enable),
        .fast      (fast),
        .pc        (pc),
        .wgm2      (ctrl_ff.wgm[2]),
        .toggle_ok (1'b1),
        .com       (ctrl_ff.com_a),
        .cnt       (counter_value_ff),
        .top       (top),
        .cmp       (cmp_a_ff),
        .up        (up_ff),
        .at_top    (at_top),
        .at_bottom (at_bottom),
        .match     (match_a),
        .wave_ff   (wave_a)
    );

    tpw_wave_ch u_ch_b
    (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .tick      (timer_clock_enable),
        .fast      (fast),
        .pc        (pc),
        .wgm2      (ctrl_ff.wgm[2]),
        .toggle_ok (1'b0),
        .com       (ctrl_ff.com_b),
        .cnt       (counter_value_ff),
        .top       (top),
        .cmp       (cmp_b_ff),
        .up        (up_ff),
        .at_top    (at_top),
        .at_bottom (at_bottom),
        .match     (match_b),
        .wave_ff   (wave_b)
    );

    // pins follow the waveform register one cycle late so outputs are flopped
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            out_a_ff <= 1'b0;
            out_b_ff <= 1'b0;
            oe_a_ff  <= 1'b0;
            oe_b_ff  <= 1'b0;
        end
        else
        begin
            out_a_ff <= wave_a;
            out_b_ff <= wave_b;
            oe_a_ff  <= (ctrl_ff.com_a != tpw_pkg::COM_OFF);
            oe_b_ff  <= (ctrl_ff.com_b != tpw_pkg::COM_OFF);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags: overflow at top in fast, at bottom in phase correct
    assign ovf_set = timer_clock_enable
                  && ((fast && at_top)
                   || (pc && at_bottom && !up_ff)
                   || (!fast && !pc && counter_value_ff == tpw_pkg::CNT_MAX));

    assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff && !err_ff;
    assign rd     = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff && !err_ff;
    assign mapped = (wb_adr_i == tpw_pkg::ADDR_CTRL) || (wb_adr_i == tpw_pkg::ADDR_CMP_A)
                 || (wb_adr_i == tpw_pkg::ADDR_CMP_B) || (wb_adr_i == tpw_pkg::ADDR_STATUS);

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            overflow_flag_ff  <= 1'b0;
            compare_a_flag_ff <= 1'b0;
            compare_b_flag_ff <= 1'b0;
        end
        else
        begin
            if (ovf_set)
                overflow_flag_ff <= 1'b1;
            else if (wr && wb_adr_i == tpw_pkg::ADDR_STATUS && wb_sel_i[0]
                     && wb_dat_i[tpw_pkg::STAT_OVF_BIT])
                overflow_flag_ff <= 1'b0;
            if (match_a)
                compare_a_flag_ff <= 1'b1;
            else if (wr && wb_adr_i == tpw_pkg::ADDR_STATUS && wb_sel_i[0]
                     && wb_dat_i[tpw_pkg::STAT_CMPA_BIT])
                compare_a_flag_ff <= 1'b0;
            if (match_b)
                compare_b_flag_ff <= 1'b1;
            else if (wr && wb_adr_i == tpw_pkg::ADDR_STATUS && wb_sel_i[0]
                     && wb_dat_i[tpw_pkg::STAT_CMPB_BIT])
                compare_b_flag_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ctrl_ff      <= '0;
            cmp_a_buf_ff <= 8'h00;
            cmp_b_buf_ff <= 8'h00;
        end
        else if (wr)
        begin
            if (wb_adr_i == tpw_pkg::ADDR_CTRL && wb_sel_i[0])
            begin
                ctrl_ff.wgm   <= wb_dat_i[tpw_pkg::CTRL_WGM_LSB +: 3];
                ctrl_ff.presc <= wb_dat_i[tpw_pkg::CTRL_PRESC_LSB +: 3];
            end
            if (wb_adr_i == tpw_pkg::ADDR_CTRL && wb_sel_i[1])
            begin
                ctrl_ff.com_b <= wb_dat_i[tpw_pkg::CTRL_COMB_LSB +: 2];
                ctrl_ff.com_a <= wb_dat_i[tpw_pkg::CTRL_COMA_LSB +: 2];
            end
            if (wb_adr_i == tpw_pkg::ADDR_CMP_A && wb_sel_i[0])
                cmp_a_buf_ff <= wb_dat_i[7:0];
            if (wb_adr_i == tpw_pkg::ADDR_CMP_B && wb_sel_i[0])
                cmp_b_buf_ff <= wb_dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux and single-wait acknowledge; unmapped addresses get err
    always_comb
    begin
        nxt_rdata = tpw_pkg::RST_ZERO;
        case (wb_adr_i)
            tpw_pkg::ADDR_CTRL:
            begin
                nxt_rdata[tpw_pkg::CTRL_WGM_LSB +: 3]   = ctrl_ff.wgm;
                nxt_rdata[tpw_pkg::CTRL_PRESC_LSB +: 3] = ctrl_ff.presc;
                nxt_rdata[tpw_pkg::CTRL_COMB_LSB +: 2]  = ctrl_ff.com_b;
                nxt_rdata[tpw_pkg::CTRL_COMA_LSB +: 2]  = ctrl_ff.com_a;
            end
            tpw_pkg::ADDR_CMP_A:  nxt_rdata[7:0] = cmp_a_buf_ff;
            tpw_pkg::ADDR_CMP_B:  nxt_rdata[7:0] = cmp_b_buf_ff;
            tpw_pkg::ADDR_STATUS:
            begin
                nxt_rdata[tpw_pkg::STAT_OVF_BIT]        = overflow_flag_ff;
                nxt_rdata[tpw_pkg::STAT_CMPA_BIT]       = compare_a_flag_ff;
                nxt_rdata[tpw_pkg::STAT_CMPB_BIT]       = compare_b_flag_ff;
                nxt_rdata[tpw_pkg::STAT_CNT_LSB +: 8]   = counter_value_ff;
            end
            default:              nxt_rdata = tpw_pkg::RST_ZERO;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ack_ff   <= 1'b0;
            err_ff   <= 1'b0;
            rdata_ff <= tpw_pkg::RST_ZERO;
        end
        else
        begin
            ack_ff   <= (wr || rd) && mapped;
            err_ff   <= (wr || rd) && !mapped;
            rdata_ff <= rd ? nxt_rdata : tpw_pkg::RST_ZERO;
        end
    end

    assign wb_ack_o         = ack_ff;
    assign wb_err_o         = err_ff;
    assign wb_dat_o         = rdata_ff;
    assign channel_a_output = out_a_ff;
    assign channel_b_output = out_b_ff;
    assign channel_a_oe     = oe_a_ff;
    assign channel_b_oe     = oe_b_ff;

endmodule : tpw_timer

// *** dv/tpw_timer_sva.sv ***
// checker: bus handshake and reset behaviour seen at the timer ports
`timescale 1ns/1ns
module tpw_timer_sva
(
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        channel_a_output,
    input wire logic        channel_b_output,
    input wire logic        channel_a_oe,
    input wire logic        channel_b_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
////////////////////////////////////////////////////////////////////////////////
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stood longer than one cycle");
    a_err_one_cycle: assert property (wb_err_o |=> !wb_err_o)
        else $error("err stood longer than one cycle");
    a_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o)
        |=> (wb_ack_o || wb_err_o)) else $error("request not answered next cycle");
    a_no_spurious: assert property ((wb_ack_o || wb_err_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("answer without a request");
    a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o))
        else $error("ack and err together");
    a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    // reset is held two edges, though the output registers reset directly and clear on the first
    a_reset_out_low: assert property (disable iff (1'h0) (!rst_b ##1 !rst_b)
        |=> (!channel_a_output && !channel_b_output)) else $error("outputs set in reset");
    a_reset_oe_low: assert property (disable iff (1'h0) (!rst_b ##1 !rst_b)
        |=> (!channel_a_oe && !channel_b_oe)) else $error("output enables set in reset");
endmodule : tpw_timer_sva

bind tpw_timer tpw_timer_sva tpw_timer_sva_inst
(
    .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .wb_dat_o(wb_dat_o),
    .channel_a_output(channel_a_output), .channel_b_output(channel_b_output),
    .channel_a_oe(channel_a_oe), .channel_b_oe(channel_b_oe)
);

// *** dv/tpw_timer_tb.sv ***
// testbench: wishbone set-up of pwm modes and waveform measurement at the pins
`timescale 1ns/1ns
module tpw_timer_tb;
    logic        ref_clk;
    logic        rst_b;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [3:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        wb_err_o;
    logic        channel_a_output;
    logic        channel_b_output;
    logic        channel_a_oe;
    logic        channel_b_oe;
    logic [31:0] rd;
    logic        er;
    int          fails;
    int          checks;
    int          hi_a;
    int          hi_b;
    int          ed_a;
    int          ed_b;

    tpw_timer tpw_timer_inst
    (
        .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .channel_a_output(channel_a_output), .channel_b_output(channel_b_output),
        .channel_a_oe(channel_a_oe), .channel_b_oe(channel_b_oe)
    );
////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // holds the request until ack or err is sampled, then releases it
    task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= w;
        wb_adr_i <= ad;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1 && n < 50);
        rd = wb_dat_o;
        er = wb_err_o;
        if (n >= 50)
            fails++;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : wb

    task automatic cfg(input logic [2:0] w, input logic [2:0] p, input logic [1:0] a,
                       input logic [1:0] b, input logic [7:0] ca, input logic [7:0] cb);
        wb(1'h1, tpw_pkg::ADDR_CMP_A, {24'h0, ca});
        wb(1'h1, tpw_pkg::ADDR_CMP_B, {24'h0, cb});
        wb(1'h1, tpw_pkg::ADDR_CTRL, {20'h0, a, b, 1'h0, p, 1'h0, w});
    endtask : cfg

    // compare buffers load at top, so a settle span precedes the window
    task automatic measure(input int settle, input int win);
        logic pa;
        logic pb;
        repeat (settle) @(posedge ref_clk);
        @(negedge ref_clk);
        pa = channel_a_output;
        pb = channel_b_output;
        hi_a = 0; hi_b = 0; ed_a = 0; ed_b = 0;
        repeat (win)
        begin
            @(negedge ref_clk);
            hi_a += (channel_a_output === 1'h1);
            hi_b += (channel_b_output === 1'h1);
            ed_a += (channel_a_output !== pa);
            ed_b += (channel_b_output !== pb);
            pa = channel_a_output;
            pb = channel_b_output;
        end
    endtask : measure

    task automatic ovf_seen();
        wb(1'h1, tpw_pkg::ADDR_STATUS, 32'h1);
        repeat (600) @(posedge ref_clk);
        wb(1'h0, tpw_pkg::ADDR_STATUS, 32'h0);
        check("overflow", rd[tpw_pkg::STAT_OVF_BIT], 32'h1);
    endtask : ovf_seen
////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("out_a", channel_a_output, 32'h0);
        check("oe_b", channel_b_oe, 32'h0);
        wb(1'h0, tpw_pkg::ADDR_CTRL, 32'h0);
        check("ctrl", rd, tpw_pkg::RST_ZERO);
        wb(1'h0, tpw_pkg::ADDR_STATUS, 32'h0);
        check("status", rd, tpw_pkg::RST_ZERO);
        wb(1'h1, 4'h2, 32'hFFFF_FFFF);
        check("err", er, 32'h1);
        wb(1'h0, 4'h2, 32'h0);
        check("err_data", rd, 32'h0);
    endtask : t_reset

    task automatic t_fast_ff();
        cfg(tpw_pkg::WGM_FAST_FF, tpw_pkg::PRESC_1, tpw_pkg::COM_NONINV,
            tpw_pkg::COM_INV, 8'h40, 8'h80);
        wb(1'h0, tpw_pkg::ADDR_CMP_A, 32'h0);
        check("cmp_a", rd, 32'h40);
        measure(1100, 512);
        check("fast_a_high", hi_a, 32'd130);
        check("fast_b_high", hi_b, 32'd254);
        check("oe_a", channel_a_oe, 32'h1);
        check("oe_b_on", channel_b_oe, 32'h1);
        ovf_seen();
    endtask : t_fast_ff

    task automatic t_fast_presc();
        cfg(tpw_pkg::WGM_FAST_FF, tpw_pkg::PRESC_8, tpw_pkg::COM_NONINV,
            tpw_pkg::COM_OFF, 8'h40, 8'h0);
        measure(4200, 2048);
        check("presc_a_high", hi_a, 32'd520);
    endtask : t_fast_presc

    task automatic t_fast_toggle();
        cfg(tpw_pkg::WGM_FAST_OCA, tpw_pkg::PRESC_1, tpw_pkg::COM_TOGGLE,
            tpw_pkg::COM_TOGGLE, 8'h0, 8'h0);
        measure(1100, 512);
        check("tgl_a_high", hi_a, 32'd256);
        check("tgl_a_edges", ed_a, 32'd512);
        check("tgl_b_edges", ed_b, 32'd0);
    endtask : t_fast_toggle

    task automatic t_fast_top_a();
        cfg(tpw_pkg::WGM_FAST_OCA, tpw_pkg::PRESC_1, tpw_pkg::COM_OFF,
            tpw_pkg::COM_NONINV, 8'h7F, 8'h1F);
        measure(1100, 512);
        check("top_a_b_high", hi_b, 32'd128);
    endtask : t_fast_top_a

    task automatic t_fast_extreme();
        cfg(tpw_pkg::WGM_FAST_FF, tpw_pkg::PRESC_1, tpw_pkg::COM_NONINV,
            tpw_pkg::COM_OFF, 8'hFF, 8'h0);
        measure(1100, 512);
        check("fmax_high", hi_a, 32'd512);
        cfg(tpw_pkg::WGM_FAST_FF, tpw_pkg::PRESC_1, tpw_pkg::COM_INV,
            tpw_pkg::COM_OFF, 8'hFF, 8'h0);
        measure(1100, 512);
        check("fmax_inv_high", hi_a, 32'd0);
        cfg(tpw_pkg::WGM_FAST_FF, tpw_pkg::PRESC_1, tpw_pkg::COM_NONINV,
            tpw_pkg::COM_OFF, 8'h0, 8'h0);
        measure(1100, 512);
        check("fzero_spike", hi_a, 32'd2);
    endtask : t_fast_extreme

    task automatic t_pc_ff();
        cfg(tpw_pkg::WGM_PC_FF, tpw_pkg::PRESC_1, tpw_pkg::COM_NONINV,
            tpw_pkg::COM_INV, 8'h40, 8'h40);
        measure(1100, 1020);
        check("pc_a_high", hi_a, 32'd256);
        check("pc_b_high", hi_b, 32'd764);
        ovf_seen();
    endtask : t_pc_ff

    task automatic t_pc_top_a();
        cfg(tpw_pkg::WGM_PC_OCA, tpw_pkg::PRESC_1, tpw_pkg::COM_OFF,
            tpw_pkg::COM_NONINV, 8'h3F, 8'h10);
        measure(1100, 1008);
        check("pc_top_b_high", hi_b, 32'd256);
    endtask : t_pc_top_a

    task automatic t_pc_extreme();
        cfg(tpw_pkg::WGM_PC_FF, tpw_pkg::PRESC_1, tpw_pkg::COM_NONINV,
            tpw_pkg::COM_OFF, 8'h0, 8'h0);
        measure(1100, 1020);
        check("pzero_high", hi_a, 32'd0);
        cfg(tpw_pkg::WGM_PC_FF, tpw_pkg::PRESC_1, tpw_pkg::COM_NONINV,
            tpw_pkg::COM_OFF, 8'hFF, 8'h0);
        measure(1100, 1020);
        check("pmax_high", hi_a, 32'd1020);
        cfg(tpw_pkg::WGM_PC_FF, tpw_pkg::PRESC_1, tpw_pkg::COM_INV,
            tpw_pkg::COM_OFF, 8'h0, 8'h0);
        measure(1100, 1020);
        check("pzero_inv_high", hi_a, 32'd1020);
    endtask : t_pc_extreme
////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end

    // the whole sequence needs about 30000 cycles
    initial
    begin
        #(8 * 60000);
        fails++;
        summarize();
    end

    initial
    begin
        fails = 0; checks = 0;
        rst_b = 1'h0; wb_cyc_i = 1'h0; wb_stb_i = 1'h0; wb_we_i = 1'h0;
        wb_adr_i = 4'h0; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'h1;
        t_reset();
        t_fast_ff();
        t_fast_presc();
        t_fast_toggle();
        t_fast_top_a();
        t_fast_extreme();
        t_pc_ff();
        t_pc_top_a();
        t_pc_extreme();
        summarize();
    end
endmodule : tpw_timer_tb
